// ==== core/ieu_defines.svh ====
// Constants of the core interrupt and exception unit.
// Assumes a 32-bit machine state word numbered with bit 0 as least significant.
`ifndef IEU_DEFINES_SVH
`define IEU_DEFINES_SVH
// Machine state bit positions, then the machine state and syndrome reset values.
`define IEU_MSR_CE      17
`define IEU_MSR_EE      15
`define IEU_MSR_PR      14
`define IEU_MSR_ME      12
`define IEU_MSR_DE      9
`define IEU_MSR_RST     32'h0000_0000
`define IEU_ESR_RST     32'h0000_0000
// Save and restore pair indices.
`define IEU_CLS_NC      2'h0
`define IEU_CLS_CR      2'h1
`define IEU_CLS_DB      2'h2
`define IEU_CLS_MC      2'h3
// Vector offset register numbers.
`define IEU_IV_CI       4'h0
`define IEU_IV_MC       4'h1
`define IEU_IV_DSI      4'h2
`define IEU_IV_ISI      4'h3
`define IEU_IV_EXT      4'h4
`define IEU_IV_ALIGN    4'h5
`define IEU_IV_PROG     4'h6
`define IEU_IV_SC       4'h8
`define IEU_IV_DEC      4'hA
`define IEU_IV_FIT      4'hB
`define IEU_IV_WDT      4'hC
`define IEU_IV_DTLB     4'hD
`define IEU_IV_ITLB     4'hE
`define IEU_IV_DBG      4'hF
// Synchronous exception request bit positions.
`define IEU_SX_ITLB     0
`define IEU_SX_ISI      1
`define IEU_SX_PROG     2
`define IEU_SX_SC       3
`define IEU_SX_ALIGN    4
`define IEU_SX_DTLB     5
`define IEU_SX_DSI      6
`define IEU_SX_N        7
`endif

// ==== core/ieu_pkg.sv ====
// Types of the core interrupt and exception unit.
// Assumes ieu_defines.svh for all numeric constants.
package ieu_pkg;
    typedef enum logic [3:0] {
        IEU_NONE, IEU_NMI, IEU_MCHK, IEU_DBG, IEU_CI, IEU_WDT,
        IEU_ITLB, IEU_ISI, IEU_PROG, IEU_SC, IEU_ALIGN, IEU_DTLB, IEU_DSI,
        IEU_EXT, IEU_DEC, IEU_FIT
    } ieu_cause_e;
endpackage : ieu_pkg

// ==== core/ieu_core.sv ====
// Interrupt and exception sequencer of a 32-bit embedded core.
// Assumes request pins are asynchronous and pipeline signals share clk_i.
`timescale 1ns/100ps
`include "ieu_defines.svh"

module ieu_core (
    // Clock and reset.
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Device pins.
    input  wire logic                      crit_irq_n_i,
    input  wire logic                      ext_irq_n_i,
    input  wire logic                      nmi_n_i,
    input  wire logic                      mcheck_n_i,
    input  wire logic                      unconditional_debug_event_i,
    input  wire logic [29:0]               rst_base_i,
    // Pipeline and internal sources.
    input  wire logic [`IEU_SX_N-1:0]      sync_exc_i,
    input  wire logic [31:0]               syndrome_i,
    input  wire logic [31:0]               exc_pc_i,
    input  wire logic [31:0]               next_pc_i,
    input  wire logic                      mc_sync_i,
    input  wire logic                      dbg_sync_i,
    input  wire logic                      dbg_imprecise_i,
    input  wire logic                      wdt_i,
    input  wire logic                      fit_i,
    input  wire logic                      dec_i,
    input  wire logic                      debug_en_i,
    input  wire logic [3:0]                return_long_i,
    input  wire logic [3:0]                return_short_i,
    input  wire logic                      msr_wr_i,
    input  wire logic [31:0]               msr_wdata_i,
    input  wire logic [15:0]               vector_prefix_i,
    input  wire logic [15:0][11:0]         vector_offset_i,
    // Results.
    output logic                           take_o,
    output logic                           flush_o,
    output logic                           redirect_o,
    output logic [31:0]                    redirect_pc_o,
    output ieu_pkg::ieu_cause_e            cause_o,
    output logic [31:0]                    machine_state_o,
    output logic [31:0]                    exception_syndrome_o,
    output logic [3:0][31:0]               save_pc_o,
    output logic [3:0][31:0]               save_state_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge capture.

    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [1:0] edge_prev;
    logic       nmi_pend;
    logic       mchk_pend;
    logic [29:0] base_s1;
    logic [29:0] base_s2;
    logic       boot;
    wire  [4:0] pin_raw = {unconditional_debug_event_i, mcheck_n_i, nmi_n_i,
                           ext_irq_n_i, crit_irq_n_i};
    wire        crit_req = ~pin_s2[0];
    wire        ext_req  = ~pin_s2[1];
    wire        nmi_fall = edge_prev[0] & ~pin_s2[2];
    wire        mcp_fall = edge_prev[1] & ~pin_s2[3];
    wire        ude_req  = pin_s2[4];

    always_ff @(posedge clk_i) begin
        pin_s1    <= pin_raw;
        pin_s2    <= pin_s1;
        base_s1   <= rst_base_i;
        base_s2   <= base_s1;
        edge_prev <= rst_i ? 2'h3 : pin_s2[3:2];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic [1:0] class_of(ieu_pkg::ieu_cause_e c, logic dbg_en);
        case (c)
            ieu_pkg::IEU_NMI, ieu_pkg::IEU_MCHK: class_of = `IEU_CLS_MC;
            ieu_pkg::IEU_DBG: class_of = dbg_en ? `IEU_CLS_DB : `IEU_CLS_CR;
            ieu_pkg::IEU_CI, ieu_pkg::IEU_WDT: class_of = `IEU_CLS_CR;
            default: class_of = `IEU_CLS_NC;
        endcase
    endfunction : class_of

    function automatic logic [3:0] vector_offset_of(ieu_pkg::ieu_cause_e c);
        case (c)
            ieu_pkg::IEU_NMI, ieu_pkg::IEU_MCHK: vector_offset_of = `IEU_IV_MC;
            ieu_pkg::IEU_DBG:   vector_offset_of = `IEU_IV_DBG;
            ieu_pkg::IEU_CI:    vector_offset_of = `IEU_IV_CI;
            ieu_pkg::IEU_WDT:   vector_offset_of = `IEU_IV_WDT;
            ieu_pkg::IEU_ITLB:  vector_offset_of = `IEU_IV_ITLB;
            ieu_pkg::IEU_ISI:   vector_offset_of = `IEU_IV_ISI;
            ieu_pkg::IEU_PROG:  vector_offset_of = `IEU_IV_PROG;
            ieu_pkg::IEU_SC:    vector_offset_of = `IEU_IV_SC;
            ieu_pkg::IEU_ALIGN: vector_offset_of = `IEU_IV_ALIGN;
            ieu_pkg::IEU_DTLB:  vector_offset_of = `IEU_IV_DTLB;
            ieu_pkg::IEU_DSI:   vector_offset_of = `IEU_IV_DSI;
            ieu_pkg::IEU_EXT:   vector_offset_of = `IEU_IV_EXT;
            ieu_pkg::IEU_DEC:   vector_offset_of = `IEU_IV_DEC;
            ieu_pkg::IEU_FIT:   vector_offset_of = `IEU_IV_FIT;
            default:            vector_offset_of = `IEU_IV_EXT;
        endcase
    endfunction : vector_offset_of

    function automatic logic is_sync(ieu_pkg::ieu_cause_e c);
        is_sync = (c >= ieu_pkg::IEU_ITLB) && (c <= ieu_pkg::IEU_DSI);
    endfunction : is_sync

    ////////////////////////////////////////////////////////////////////////////////
    // Enables and priority selection.

    logic [31:0] machine_state;
    logic [31:0] exception_syndrome;
    wire  ce = machine_state[`IEU_MSR_CE];
    wire  ee = machine_state[`IEU_MSR_EE];
    wire  me = machine_state[`IEU_MSR_ME];
    wire  de = machine_state[`IEU_MSR_DE];
    // A debug event routed to the critical pair obeys the critical enable too.
    wire  dbg_ok  = de & (debug_en_i | ce);
    wire  mc_on   = me & (mchk_pend | mc_sync_i);
    wire  dbg_on  = dbg_ok & (dbg_sync_i | ude_req | dbg_imprecise_i);
    wire  ci_on   = ce & crit_req;
    wire  wdt_on  = ce & wdt_i;
    wire  ext_on  = ee & ext_req;
    wire  dec_on  = ee & dec_i;
    wire  fit_on  = ee & fit_i;

    // Precise sources beat imprecise ones of the non-critical class so no younger effect escapes.
    ieu_pkg::ieu_cause_e sel;
    assign sel = nmi_pend                  ? ieu_pkg::IEU_NMI   :
                 mc_on                     ? ieu_pkg::IEU_MCHK  :
                 dbg_on                    ? ieu_pkg::IEU_DBG   :
                 ci_on                     ? ieu_pkg::IEU_CI    :
                 wdt_on                    ? ieu_pkg::IEU_WDT   :
                 sync_exc_i[`IEU_SX_ITLB]  ? ieu_pkg::IEU_ITLB  :
                 sync_exc_i[`IEU_SX_ISI]   ? ieu_pkg::IEU_ISI   :
                 sync_exc_i[`IEU_SX_PROG]  ? ieu_pkg::IEU_PROG  :
                 sync_exc_i[`IEU_SX_SC]    ? ieu_pkg::IEU_SC    :
                 sync_exc_i[`IEU_SX_ALIGN] ? ieu_pkg::IEU_ALIGN :
                 sync_exc_i[`IEU_SX_DTLB]  ? ieu_pkg::IEU_DTLB  :
                 sync_exc_i[`IEU_SX_DSI]   ? ieu_pkg::IEU_DSI   :
                 ext_on                    ? ieu_pkg::IEU_EXT   :
                 dec_on                    ? ieu_pkg::IEU_DEC   :
                 fit_on                    ? ieu_pkg::IEU_FIT   :
                                             ieu_pkg::IEU_NONE;

    wire        take     = (sel != ieu_pkg::IEU_NONE) & ~boot;
    wire [1:0]  take_cls = class_of(sel, debug_en_i);
    wire [31:0] take_pc  = is_sync(sel) ? exc_pc_i : next_pc_i;
    wire [31:0] take_vec = {vector_prefix_i, vector_offset_i[vector_offset_of(sel)], 4'h0};
    wire [3:0]  ret_any  = return_long_i | return_short_i;
    wire        ret      = |ret_any & ~take & ~boot;
    wire [1:0]  ret_cls  = ret_any[3] ? `IEU_CLS_MC :
                           ret_any[2] ? `IEU_CLS_DB :
                           ret_any[1] ? `IEU_CLS_CR : `IEU_CLS_NC;

    assign take_o  = take;
    assign flush_o = take;

    ////////////////////////////////////////////////////////////////////////////////
    // Machine state update on take, return and software write.

    logic [31:0] msr_taken;
    always_comb begin
        msr_taken = machine_state;
        msr_taken[`IEU_MSR_PR] = 1'b0;
        msr_taken[`IEU_MSR_EE] = 1'b0;
        if (take_cls != `IEU_CLS_NC) begin
            msr_taken[`IEU_MSR_CE] = 1'b0;
        end
        if (take_cls == `IEU_CLS_MC) begin
            msr_taken[`IEU_MSR_ME] = 1'b0;
        end
        if (take_cls == `IEU_CLS_DB) begin
            msr_taken[`IEU_MSR_DE] = 1'b0;
        end
    end

    wire [31:0] next_msr = take     ? msr_taken :
                           ret      ? save_state_o[ret_cls] :
                           msr_wr_i ? msr_wdata_i : machine_state;

    // A pending edge that lands on the cycle it is taken stays pending.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            machine_state       <= `IEU_MSR_RST;
            exception_syndrome       <= `IEU_ESR_RST;
            nmi_pend  <= 1'b0;
            mchk_pend <= 1'b0;
            boot      <= 1'b1;
        end else begin
            machine_state       <= next_msr;
            exception_syndrome       <= (take && is_sync(sel)) ? syndrome_i : exception_syndrome;
            nmi_pend  <= nmi_fall | (nmi_pend & ~(take && sel == ieu_pkg::IEU_NMI));
            mchk_pend <= mcp_fall | (mchk_pend & ~(take && sel == ieu_pkg::IEU_MCHK));
            boot      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Save and restore pairs, one per class.

    for (genvar g = 0; g < 4; g++) begin : g_pair
        wire hit = take & (take_cls == 2'(g));
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                save_pc_o[g]    <= 32'h0000_0000;
                save_state_o[g] <= 32'h0000_0000;
            end else if (hit) begin
                save_pc_o[g]    <= take_pc;
                save_state_o[g] <= machine_state;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fetch redirection and visible state.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            redirect_o    <= 1'b0;
            redirect_pc_o <= 32'h0000_0000;
            cause_o       <= ieu_pkg::IEU_NONE;
        end else begin
            redirect_o    <= boot | take | ret;
            redirect_pc_o <= boot ? {base_s2, 2'b00} :
                             take ? take_vec : save_pc_o[ret_cls];
            cause_o       <= take ? sel : cause_o;
        end
    end

    assign machine_state_o      = machine_state;
    assign exception_syndrome_o = exception_syndrome;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    wire cause_is_nmi = (sel == ieu_pkg::IEU_NMI);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ENABLED_ONLY: assert property (take && sel == ieu_pkg::IEU_EXT |-> ee && ext_req)
        else $error("external interrupt taken while disabled");
    AST_EXT_ENABLE: assert property (!ee |-> sel != ieu_pkg::IEU_EXT)
        else $error("external input selected with enable clear");
    AST_VECTOR: assert property (take |=> redirect_o && redirect_pc_o == $past(take_vec))
        else $error("vector fetch does not follow take");
    AST_SUPERVISOR: assert property (take |=> !machine_state_o[`IEU_MSR_PR])
        else $error("handler not in supervisor mode");
    AST_SYNDROME: assert property (take && is_sync(sel) |=> exception_syndrome == $past(syndrome_i))
        else $error("syndrome not updated");
    AST_NEST_NC: assert property (take && take_cls != `IEU_CLS_NC |=> $stable(save_pc_o[0]))
        else $error("outer non-critical pair corrupted");
    AST_MC_PAIR: assert property (take && take_cls == `IEU_CLS_MC
                                  |=> save_pc_o[3] == $past(take_pc))
        else $error("machine check pair not written");
    AST_RETURN: assert property (ret |=> machine_state == $past(save_state_o[ret_cls])
                                 && redirect_pc_o == $past(save_pc_o[ret_cls]))
        else $error("return did not restore its pair");
    AST_FLUSH: assert property (take && is_sync(sel) |-> flush_o)
        else $error("precise take without flush");
    AST_CRIT_CLASS: assert property (take && sel == ieu_pkg::IEU_WDT
                                     |-> take_cls == `IEU_CLS_CR)
        else $error("watchdog not critical class");
    AST_NMI_EDGE: assert property (nmi_fall && !boot |=> ##[0:2] take && cause_is_nmi)
        else $error("non-maskable edge not taken");
    AST_RESET_VEC: assert property ($fell(rst_i) |=> redirect_o
                                    && redirect_pc_o[1:0] == 2'b00)
        else $error("reset fetch missing");
    AST_PRIORITY: assert property (nmi_pend && !boot |-> take && sel == ieu_pkg::IEU_NMI)
        else $error("machine check class not preferred");
    AST_CLASS_MASK: assert property (take && take_cls == `IEU_CLS_CR
                                     |=> !machine_state_o[`IEU_MSR_CE])
        else $error("critical enable not cleared");

    COV_NEST: cover property (take && take_cls == `IEU_CLS_NC ##[1:20] take
                              && take_cls == `IEU_CLS_CR);
    COV_RETURN: cover property (take ##[1:20] ret);
    COV_NMI: cover property (take && sel == ieu_pkg::IEU_NMI);
    COV_DEBUG_PAIR: cover property (take && take_cls == `IEU_CLS_DB);

endmodule : ieu_core

// ==== testbench/ieu_pipe_model.sv ====
// Behavioural instruction pipeline facing the interrupt and exception unit.
// Assumes redirect and flush come from the unit on the shared core clock.
`timescale 1ns/100ps

module ieu_pipe_model (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Control from the unit.
    input  wire logic        flush_i,
    input  wire logic        redirect_i,
    input  wire logic [31:0] redirect_pc_i,
    // Program counters offered to the unit.
    output logic      [31:0] exc_pc_o,
    output logic      [31:0] next_pc_o
);
    logic [31:0] pc;

    // A flushed cycle makes no progress, so no younger instruction retires.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= 32'h0000_0000;
        end else if (redirect_i) begin
            pc <= redirect_pc_i;
        end else if (!flush_i) begin
            pc <= pc + 32'h0000_0004;
        end
    end

    assign exc_pc_o  = pc;
    assign next_pc_o = pc + 32'h0000_0004;
endmodule : ieu_pipe_model

// ==== testbench/test_core_interrupt_exception_unit.sv ====
// Self-checking bench of the interrupt and exception unit.
// Assumes the pipeline model stands beside the unit and requests are driven by hand.
`timescale 1ns/100ps
`include "ieu_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end

module test_core_interrupt_exception_unit;
    logic clk_i = 1'b0, rst_i = 1'b1, crit_n = 1'b1, ext_n = 1'b1, nmi_n = 1'b1, unconditional_debug_event = 1'b0;
    logic wdt = 1'b0, dec = 1'b0, debug_en = 1'b0, msr_wr = 1'b0, fit = 1'b0, mcheck_n = 1'b1;
    logic [6:0] sync_exc = 7'h00;
    logic [3:0] ret_l = 4'h0, ret_s = 4'h0;
    logic [31:0] syndrome = 32'h0000_0000, msr_wd = 32'h0000_0000, exc_pc, next_pc;
    logic [29:0] rst_base = 30'h0123_4567;
    logic [15:0] prefix = 16'hABC0;
    logic [15:0][11:0] vo;
    logic take_o, flush_o, redirect_o;
    logic [31:0] redirect_pc_o, machine_state_o, exception_syndrome_o, exp_msr;
    logic [3:0][31:0] save_pc_o, save_state_o, exp_pc, exp_st;
    ieu_pkg::ieu_cause_e cause_o;
    int miscompares = 0, cmp_count = 0, cycles = 0;

    ieu_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .crit_irq_n_i(crit_n), .ext_irq_n_i(ext_n),
        .nmi_n_i(nmi_n), .mcheck_n_i(mcheck_n), .unconditional_debug_event_i(unconditional_debug_event),
        .rst_base_i(rst_base), .sync_exc_i(sync_exc), .syndrome_i(syndrome), .exc_pc_i(exc_pc),
        .next_pc_i(next_pc), .mc_sync_i(1'b0), .dbg_sync_i(1'b0), .dbg_imprecise_i(1'b0),
        .wdt_i(wdt), .fit_i(fit), .dec_i(dec), .debug_en_i(debug_en), .return_long_i(ret_l),
        .return_short_i(ret_s), .msr_wr_i(msr_wr), .msr_wdata_i(msr_wd),
        .vector_prefix_i(prefix), .vector_offset_i(vo), .take_o(take_o), .flush_o(flush_o),
        .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o), .cause_o(cause_o),
        .machine_state_o(machine_state_o), .exception_syndrome_o(exception_syndrome_o),
        .save_pc_o(save_pc_o), .save_state_o(save_state_o));

    ieu_pipe_model u_pipe (.clk_i(clk_i), .rst_i(rst_i), .flush_i(flush_o),
        .redirect_i(redirect_o), .redirect_pc_i(redirect_pc_o), .exc_pc_o(exc_pc),
        .next_pc_o(next_pc));

    always #4 clk_i = ~clk_i;

    // A hung wait would otherwise never reach the verdict.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic check_pairs();
        for (int i = 0; i < 4; i++) begin
            `CHK("save_pc", exp_pc[i], save_pc_o[i])
            `CHK("save_state", exp_st[i], save_state_o[i])
        end
    endtask : check_pairs

    task automatic msr_write(input logic [31:0] v);
        msr_wr = 1'b1;
        msr_wd = v;
        @(posedge clk_i);
        #1;
        msr_wr = 1'b0;
        exp_msr = v;
    endtask : msr_write

    task automatic no_take(input int k);
        repeat (k) begin
            @(negedge clk_i);
            `CHK("no_take", 1'b0, take_o)
        end
        @(posedge clk_i);
        #1;
    endtask : no_take

    // Waits for one take, then checks vector, state, cause and all four pairs.
    task automatic take(input ieu_pkg::ieu_cause_e c, input logic [3:0] iv, input int cls,
                        input bit sync);
        int n;
        logic [31:0] spc;
        n = 0;
        @(negedge clk_i);
        while (take_o !== 1'b1 && n < 8) begin
            n++;
            @(negedge clk_i);
        end
        `CHK("take", 1'b1, take_o)
        `CHK("flush", 1'b1, flush_o)
        spc = sync ? exc_pc : next_pc;
        @(posedge clk_i);
        #1;
        exp_pc[cls] = spc;
        exp_st[cls] = exp_msr;
        exp_msr &= ~32'h0000_C000;
        if (cls != 0) exp_msr[`IEU_MSR_CE] = 1'b0;
        if (cls == 3) exp_msr[`IEU_MSR_ME] = 1'b0;
        if (cls == 2) exp_msr[`IEU_MSR_DE] = 1'b0;
        `CHK("cause", c, cause_o)
        `CHK("redirect", 1'b1, redirect_o)
        `CHK("vector", {prefix, vo[iv], 4'h0}, redirect_pc_o)
        `CHK("state", exp_msr, machine_state_o)
        check_pairs();
    endtask : take

    task automatic ret(input bit short_form, input int cls);
        if (short_form)
            ret_s[cls] = 1'b1;
        else
            ret_l[cls] = 1'b1;
        @(posedge clk_i);
        #1;
        ret_s = 4'h0;
        ret_l = 4'h0;
        exp_msr = exp_st[cls];
        `CHK("ret_redirect", 1'b1, redirect_o)
        `CHK("ret_pc", exp_pc[cls], redirect_pc_o)
        `CHK("ret_state", exp_msr, machine_state_o)
        check_pairs();
        // One idle edge keeps a following return from re-raising a strobe just lowered.
        @(posedge clk_i);
        #1;
    endtask : ret

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        int n;
        n = 0;
        @(negedge clk_i);
        while (redirect_o !== 1'b1 && n < 6) begin
            n++;
            @(negedge clk_i);
        end
        `CHK("reset_pc", {rst_base, 2'b00}, redirect_pc_o)
        `CHK("reset_state", 32'h0000_0000, machine_state_o)
        @(posedge clk_i);
        #1;
    endtask : t_reset

    task automatic t_mask();
        ext_n = 1'b0;
        dec = 1'b1;
        no_take(6);
        msr_write(32'h0000_C000);
        take(ieu_pkg::IEU_EXT, `IEU_IV_EXT, `IEU_CLS_NC, 1'b0);
        ext_n = 1'b1;
        no_take(4);
        dec = 1'b0;
    endtask : t_mask

    task automatic t_sync();
        syndrome = 32'h0000_0880;
        sync_exc = 7'h41;
        take(ieu_pkg::IEU_ITLB, `IEU_IV_ITLB, `IEU_CLS_NC, 1'b1);
        `CHK("syndrome", 32'h0000_0880, exception_syndrome_o)
        sync_exc = 7'h40;
        syndrome = 32'h0100_0000;
        take(ieu_pkg::IEU_DSI, `IEU_IV_DSI, `IEU_CLS_NC, 1'b1);
        `CHK("syndrome", 32'h0100_0000, exception_syndrome_o)
        sync_exc = 7'h00;
    endtask : t_sync

    task automatic t_nest();
        msr_write(32'h0002_1000);
        wdt = 1'b1;
        take(ieu_pkg::IEU_WDT, `IEU_IV_WDT, `IEU_CLS_CR, 1'b0);
        wdt = 1'b0;
        nmi_n = 1'b0;
        take(ieu_pkg::IEU_NMI, `IEU_IV_MC, `IEU_CLS_MC, 1'b0);
        nmi_n = 1'b1;
        ret(1'b1, `IEU_CLS_MC);
        ret(1'b0, `IEU_CLS_CR);
    endtask : t_nest

    task automatic t_prio();
        msr_write(32'h0000_0000);
        crit_n = 1'b0;
        wdt = 1'b1;
        ext_n = 1'b0;
        no_take(4);
        msr_write(32'h0002_8000);
        take(ieu_pkg::IEU_CI, `IEU_IV_CI, `IEU_CLS_CR, 1'b0);
        no_take(4);
        crit_n = 1'b1;
        wdt = 1'b0;
        ext_n = 1'b1;
        // The released pins still read asserted until the synchronisers flush.
        no_take(2);
    endtask : t_prio

    task automatic t_mcheck();
        msr_write(32'h0000_9000);
        fit = 1'b1;
        mcheck_n = 1'b0;
        take(ieu_pkg::IEU_FIT, `IEU_IV_FIT, `IEU_CLS_NC, 1'b0);
        fit = 1'b0;
        take(ieu_pkg::IEU_MCHK, `IEU_IV_MC, `IEU_CLS_MC, 1'b0);
        mcheck_n = 1'b1;
        ret(1'b1, `IEU_CLS_MC);
        ret(1'b1, `IEU_CLS_NC);
    endtask : t_mcheck

    task automatic t_debug();
        msr_write(32'h0002_0200);
        debug_en = 1'b1;
        unconditional_debug_event = 1'b1;
        take(ieu_pkg::IEU_DBG, `IEU_IV_DBG, `IEU_CLS_DB, 1'b0);
        unconditional_debug_event = 1'b0;
        no_take(2);
        ret(1'b0, `IEU_CLS_DB);
    endtask : t_debug

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 16; i++) begin
            vo[i] = 12'h100 + 12'(i * 8);
        end
        exp_pc = '0;
        exp_st = '0;
        exp_msr = 32'h0000_0000;
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_reset();
        t_mask();
        t_sync();
        t_nest();
        t_prio();
        t_mcheck();
        t_debug();
        complete_run();
    end
endmodule : test_core_interrupt_exception_unit
